// ===== rtl/sdc_pkg.sv
package sdc_pkg;

	// Converter run phase.
	typedef enum logic [0:0]
	{
		SDC_FROZEN = 1'b0,
		SDC_RUN    = 1'b1
	} sdc_phase_e;

	typedef logic [15:0] sdc_word_t;
	typedef logic [7:0]  sdc_addr_t;

endpackage

// ===== rtl/sdc_regs.svh
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// Register offsets on the peripheral bus.
`define SDC_OFF_DATA_BASE  8'h00
`define SDC_OFF_CSR        8'h20
`define SDC_OFF_CPR        8'h30

// Reset values.
`define SDC_CSR_RESET      16'h0000
`define SDC_CPR_RESET      7'h06

// Control/status field positions.
`define SDC_CSR_LOW_RATE   14
`define SDC_CSR_OVR        13
`define SDC_CSR_IE_HI      11
`define SDC_CSR_IE_LO      8
`define SDC_CSR_SINGLE     6
`define SDC_CSR_SEL_HI     5
`define SDC_CSR_SEL_LO     4
`define SDC_CSR_DA_HI      3
`define SDC_CSR_DA_LO      0

// Frame and decimation counts in oversampling cycles.
`define SDC_NORM_FRAME     13'd512
`define SDC_LOW_FRAME      13'd5120
`define SDC_NORM_DEC       11'd170
`define SDC_LOW_DEC        11'd1700
`define SDC_KEEP_SLOT      2'd3
`define SDC_MIN_PRESC      7'd2

// Filter word layout.
`define SDC_ACC_W          33
`define SDC_NORM_W         21
`define SDC_NORM_MSB       20
`define SDC_NORM_LSB       5
`define SDC_LOW_MSB        32
`define SDC_LOW_LSB        17

`endif

// ===== rtl/sdc_sinc3.sv
`timescale 1ns/1ns
`include "sdc_regs.svh"
module sdc_sinc3 (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              tick_i,
	input  wire logic              clear_i,
	input  wire logic              bit_i,
	input  wire logic              low_rate_i,
	output sdc_pkg::sdc_word_t     result_o
);
	import sdc_pkg::*;

	localparam int AW = `SDC_ACC_W;

	typedef struct packed
	{
		logic [AW-1:0] i1;
		logic [AW-1:0] i2;
		logic [AW-1:0] i3;
		logic [AW-1:0] d1;
		logic [AW-1:0] d2;
		logic [AW-1:0] d3;
		logic [AW-1:0] dout;
		logic [10:0]   dcnt;
	} sdc_sinc_s;

	sdc_sinc_s s;
	sdc_sinc_s next_s;

	// Normal mode keeps 21-bit words; wrap is harmless in a sinc filter.
	function automatic logic [AW-1:0] fit(input logic [AW-1:0] v,
		input logic low);
		logic [AW-1:0] m;
		m = low ? '1 : {{(AW-`SDC_NORM_W){1'b0}}, {`SDC_NORM_W{1'b1}}};
		return v & m;
	endfunction

	// Integrators run every oversampling cycle, differentiators decimated.
	always_comb
	begin
		logic [AW-1:0] x;
		logic [AW-1:0] c1;
		logic [AW-1:0] c2;
		logic [AW-1:0] c3;
		logic [10:0]   last;
		x = bit_i ? {{(AW-1){1'b0}}, 1'b1} : '1;
		c1 = '0;
		c2 = '0;
		c3 = '0;
		last = low_rate_i ? `SDC_LOW_DEC : `SDC_NORM_DEC; // see RULE_02
		next_s = s;
		if (clear_i)
			next_s = '0; // see RULE_04
		else if (tick_i)
		begin
			next_s.i1 = fit(s.i1 + x, low_rate_i); // see RULE_01
			next_s.i2 = fit(s.i2 + s.i1, low_rate_i);
			next_s.i3 = fit(s.i3 + s.i2, low_rate_i);
			if (s.dcnt == last)
			begin
				c1 = fit(s.i3 - s.d1, low_rate_i);
				c2 = fit(c1 - s.d2, low_rate_i);
				c3 = fit(c2 - s.d3, low_rate_i);
				next_s.d1 = s.i3;
				next_s.d2 = c1;
				next_s.d3 = c2;
				next_s.dout = c3;
				next_s.dcnt = '0;
			end
			else
				next_s.dcnt = s.dcnt + 11'd1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			s <= '0;
		else
			s <= next_s;
	end

	// Only 16 bits leave the filter; the low-order bits are dropped.
	assign result_o = low_rate_i
		? s.dout[`SDC_LOW_MSB:`SDC_LOW_LSB]   // see RULE_03
		: s.dout[`SDC_NORM_MSB:`SDC_NORM_LSB]; // see RULE_01
endmodule

// ===== rtl/sdc_sync.sv
`timescale 1ns/1ns
module sdc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	import sdc_pkg::*;

	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdc_sync_s;

	sdc_sync_s s;
	sdc_sync_s next_s;

	// The first stage feeds only the second stage.
	always_comb
	begin
		next_s.s1 = d_i;
		next_s.s2 = s.s1;
	end

	// Two stages resolve metastability on the pin level.
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign q_o = s.s2;
endmodule

// ===== rtl/sdc_top.sv
// Contract
// RULE_01: Normal filter words 21 bits, output 16.
// RULE_02: Differentiators update at count 170 or 1700.
// RULE_03: Low-rate words 33 bits, output bits 32:17.
// RULE_04: Filter reset every 512 or 5120 cycles.
// RULE_05: Result stored as signed 16-bit two's complement.
// RULE_06: Analog part off while analog enable clear.
// RULE_07: Software discards first sample after enable.
// RULE_08: Control/status at 20h, reset 0, reserved zero.
// RULE_09: Bit 14 selects low-rate decimation.
// RULE_10: Overrun bit 13, write 0 clears.
// RULE_11: Bits 11:8 are per-channel interrupt enables.
// RULE_12: Bit 6 picks round-robin or single channel.
// RULE_13: Bits 5:4 choose the single channel.
// RULE_14: Data-available bits set by hardware, cleared.
// RULE_15: Data-available bits act as interrupt flags.
// RULE_16: Prescaler at 30h, reset 6, write-only.
// RULE_17: Round-robin: 512 cycles per channel, in order.
// RULE_18: Single channel keeps one result in four.
// RULE_19: Request needs all flags or selected flag.
// RULE_20: Oversampling clock is bus clock over 2*prescale.
// RULE_21: Overrun when storing over unread sample.
// RULE_22: Modulator crossings pass two-stage synchronisers.
`timescale 1ns/1ns
`include "sdc_regs.svh"
module sdc_top #(
	parameter logic [12:0] LOW_FRAME = `SDC_LOW_FRAME
) (
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	input  wire logic               sel_i,
	input  wire logic               enable_i,
	input  wire logic               write_i,
	input  wire sdc_pkg::sdc_addr_t addr_i,
	input  wire sdc_pkg::sdc_word_t wdata_i,
	input  wire logic               ana_enable_i,
	input  wire logic               mod_bit_i,
	output sdc_pkg::sdc_word_t      rdata_o,
	output logic                    irq_o,
	output logic                    mod_clk_o,
	output logic                    mod_rst_o,
	output logic [1:0]              mod_chan_o,
	output logic                    ana_en_o
);
	import sdc_pkg::*;

	typedef struct packed
	{
		logic             low_rate;
		logic             ovr;
		logic [3:0]       ie;
		logic             single;
		logic [1:0]       sel;
		logic [3:0]       da;
		logic [6:0]       presc;
		logic [3:0][15:0] data;
		logic [7:0]       pcnt;
		logic             mclk;
		logic [12:0]      fcnt;
		logic [1:0]       slot;
		logic [1:0]       chan;
		logic             done;
		sdc_phase_e       phase;
		sdc_word_t        rdata;
		logic             irq;
		logic             mrst;
		logic             ana_en;
	} sdc_top_s;

	sdc_top_s  s;
	sdc_top_s  next_s;
	logic      mod_bit;
	sdc_word_t result;
	logic      tick;
	logic      clear;
	logic      frame_end;
	logic [12:0] frame_last;
	logic      rd_setup;
	logic      rd_access;
	logic      wr_access;

	// Data registers sit at 00h, 08h, 10h and 18h.
	function automatic logic is_data(input sdc_addr_t a);
		return a[7:5] == 3'b000 && a[2:0] == 3'b000;
	endfunction

	// Pin level from the modulator is synchronised before use.
	sdc_sync #(
		.W (1)
	) u_bit_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.d_i      (mod_bit_i), // see RULE_22
		.q_o      (mod_bit)
	);

	sdc_sinc3 u_filter (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.tick_i     (tick),
		.clear_i    (clear),
		.bit_i      (mod_bit),
		.low_rate_i (s.low_rate),
		.result_o   (result)
	);

	// Bus phases: setup captures read data, access commits side effects.
	assign rd_setup  = sel_i && !enable_i && !write_i;
	assign rd_access = sel_i && enable_i && !write_i;
	assign wr_access = sel_i && enable_i && write_i;

	// One oversampling cycle spans twice the prescale in bus clocks.
	// The counter may stand past the new end after a prescale write, so the
	// compare is inclusive; an exact match would wrap through 256 counts.
	assign tick = s.phase == SDC_RUN && s.presc >= `SDC_MIN_PRESC
		&& s.pcnt >= {s.presc, 1'b0} - 8'd1; // see RULE_20
	assign frame_last = s.low_rate ? LOW_FRAME - 13'd1
		: `SDC_NORM_FRAME - 13'd1; // see RULE_09
	assign clear = tick && s.fcnt == 13'd0; // see RULE_17
	// Inclusive end: a switch to the short frame mid-frame ends it at once
	// instead of running the 13-bit counter all the way round.
	assign frame_end = tick && s.fcnt >= frame_last;

	// Next-state logic: bus effects first, hardware sets last so they win.
	always_comb
	begin
		logic store;
		next_s = s;
		store = s.done && (!s.single || s.slot == `SDC_KEEP_SLOT);
		next_s.done = frame_end;
		next_s.ana_en = ana_enable_i; // see RULE_06
		// Running needs power and a prescale of at least two.
		if (s.ana_en && s.presc >= `SDC_MIN_PRESC)
			next_s.phase = SDC_RUN;
		else
			next_s.phase = SDC_FROZEN; // see RULE_20
		if (s.phase == SDC_FROZEN)
		begin
			next_s.pcnt = '0;
			next_s.fcnt = '0;
			next_s.mclk = 1'b0;
		end
		else
		begin
			next_s.pcnt = tick ? 8'h00 : s.pcnt + 8'h01;
			if (s.pcnt == {1'b0, s.presc} - 8'd1 || tick)
				next_s.mclk = !s.mclk;
			if (tick)
				next_s.fcnt = frame_end ? 13'd0 : s.fcnt + 13'd1; // see RULE_04
		end
		next_s.mrst = s.phase == SDC_RUN && s.fcnt == 13'd0; // see RULE_17
		// Register writes.
		if (wr_access && addr_i == `SDC_OFF_CSR)
		begin
			next_s.low_rate = wdata_i[`SDC_CSR_LOW_RATE]; // see RULE_09
			next_s.ovr = s.ovr & wdata_i[`SDC_CSR_OVR]; // see RULE_10
			next_s.ie = wdata_i[`SDC_CSR_IE_HI:`SDC_CSR_IE_LO]; // see RULE_11
			next_s.single = wdata_i[`SDC_CSR_SINGLE]; // see RULE_12
			next_s.sel = wdata_i[`SDC_CSR_SEL_HI:`SDC_CSR_SEL_LO]; // see RULE_13
			next_s.da = s.da & wdata_i[`SDC_CSR_DA_HI:`SDC_CSR_DA_LO]; // see RULE_14
		end
		if (wr_access && addr_i == `SDC_OFF_CPR)
			next_s.presc = wdata_i[6:0]; // see RULE_16
		// Reading a data register retires its sample.
		if (rd_access && is_data(addr_i))
			next_s.da[addr_i[4:3]] = 1'b0; // see RULE_14
		// Read data is captured in setup so it is valid during access.
		if (rd_setup)
		begin
			if (is_data(addr_i))
				next_s.rdata = s.data[addr_i[4:3]];
			else if (addr_i == `SDC_OFF_CSR)
				next_s.rdata = {1'b0, s.low_rate, s.ovr, 1'b0, s.ie,
					1'b0, s.single, s.sel, s.da}; // see RULE_08
			else
				next_s.rdata = 16'h0000; // see RULE_16
		end
		// Store the finished frame; one in four is kept in single mode.
		if (s.done)
			next_s.slot = s.slot + 2'd1; // see RULE_18
		if (store)
		begin
			next_s.data[s.chan] = result; // see RULE_05
			if (s.da[s.chan])
				next_s.ovr = 1'b1; // see RULE_21
			next_s.da[s.chan] = 1'b1; // see RULE_14
			if (!s.single)
				next_s.chan = s.chan + 2'd1; // see RULE_17
		end
		if (s.single)
			next_s.chan = s.sel; // see RULE_13
		// The flags double as interrupt sources.
		if (s.single)
			next_s.irq = s.da[s.sel] && s.ie[s.sel]; // see RULE_19
		else
			next_s.irq = &(s.da & s.ie); // see RULE_15
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			s <= '0;
			s.presc <= `SDC_CPR_RESET; // see RULE_16
			s.phase <= SDC_FROZEN;
		end
		else
			s <= next_s;
	end

	assign rdata_o    = s.rdata;
	assign irq_o      = s.irq;
	assign mod_clk_o  = s.mclk;
	assign mod_rst_o  = s.mrst;
	assign mod_chan_o = s.chan;
	assign ana_en_o   = s.ana_en;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	frozen_clock_a: assert property ( // see RULE_20
		s.phase == SDC_FROZEN |=> !mod_clk_o && s.pcnt == 8'h00)
		else $error("oversampling clock runs while frozen");

	ovr_keep_a: assert property ( // see RULE_10
		wr_access && addr_i == `SDC_OFF_CSR && wdata_i[`SDC_CSR_OVR]
		&& !s.ovr && !s.done |=> !s.ovr)
		else $error("writing one set overrun");

	presc_write_a: assert property ( // see RULE_16
		wr_access && addr_i == `SDC_OFF_CPR
		|=> s.presc == $past(wdata_i[6:0]))
		else $error("prescaler write lost");

	low_rate_wr_a: assert property ( // see RULE_09
		wr_access && addr_i == `SDC_OFF_CSR
		|=> s.low_rate == $past(wdata_i[`SDC_CSR_LOW_RATE]))
		else $error("decimation select write lost");

	irq_enable_a: assert property ( // see RULE_11
		wr_access && addr_i == `SDC_OFF_CSR
		|=> s.ie == $past(wdata_i[`SDC_CSR_IE_HI:`SDC_CSR_IE_LO]))
		else $error("interrupt enable write lost");

	// A read only clears its flag when no store to that channel lands in the same cycle.
	read_clear_a: assert property ( // see RULE_14
		rd_access && is_data(addr_i) && !s.done
		|=> !s.da[$past(addr_i[4:3])])
		else $error("data read did not clear its flag");

	frame_reset_a: assert property ( // see RULE_17
		s.phase == SDC_RUN && s.fcnt == 13'd0 |=> mod_rst_o)
		else $error("modulator reset missing at frame start");

	irq_single_a: assert property ( // see RULE_19
		s.single && s.da[s.sel] && s.ie[s.sel] |=> irq_o)
		else $error("single channel request missing");

	result_store_a: assert property ( // see RULE_05
		s.done && !s.single |=> s.data[$past(s.chan)] == $past(result))
		else $error("filter result not stored");

	ana_follow_a: assert property ( // see RULE_06
		1'b1 |=> ana_en_o == $past(ana_enable_i))
		else $error("analog enable not followed");

	tick_space_a: assert property ( // see RULE_20
		tick |=> !tick [*3])
		else $error("oversampling ticks too close");

	csr_rsvd_a: assert property ( // see RULE_08
		rd_setup && addr_i == `SDC_OFF_CSR
		|=> rdata_o[15] == 1'b0 && rdata_o[12] == 1'b0 && rdata_o[7] == 1'b0)
		else $error("reserved control bits read nonzero");

	cpr_read_a: assert property ( // see RULE_16
		rd_setup && addr_i == `SDC_OFF_CPR |=> rdata_o == 16'h0000)
		else $error("prescaler read not zero");

	frame_wrap_a: assert property ( // see RULE_04
		frame_end |=> s.fcnt == 13'd0 && s.done)
		else $error("frame did not restart");

	store_flag_a: assert property ( // see RULE_14
		s.done && !s.single |=> s.da[$past(s.chan)]
		&& s.chan == $past(s.chan) + 2'd1)
		else $error("round-robin store missing");

	overrun_set_a: assert property ( // see RULE_21
		s.done && !s.single && s.da[s.chan] |=> s.ovr)
		else $error("overrun not flagged");

	irq_all_a: assert property ( // see RULE_19
		!s.single && (s.da & s.ie) == 4'hF ##1 !$past(s.single)
		|-> irq_o)
		else $error("round-robin request missing");

	single_chan_a: assert property ( // see RULE_13
		s.single && $stable(s.sel) |=> mod_chan_o == $past(s.sel))
		else $error("single channel not followed");
endmodule

// ===== tb/sdc_top_tb.sv
`timescale 1ns/1ns
module sdc_top_tb;
	import sdc_pkg::*;
	typedef struct {sdc_word_t v; sdc_word_t m;} sdc_note_s;

	logic       clk_i        = 1'b0;
	logic       resetn_i     = 1'b0;
	logic       sel_i        = 1'b0;
	logic       enable_i     = 1'b0;
	logic       write_i      = 1'b0;
	sdc_addr_t  addr_i       = 8'h00;
	sdc_word_t  wdata_i      = 16'h0000;
	logic       ana_enable_i = 1'b0;
	logic       mod_bit_i    = 1'b0;
	sdc_word_t  rdata_o;
	logic       irq_o;
	logic       mod_clk_o;
	logic       mod_rst_o;
	logic [1:0] mod_chan_o;
	logic       ana_en_o;
	sdc_note_s  notes[$];
	sdc_note_s  e;
	sdc_word_t  d;
	bit         chk          = 1'b0;
	int         n_mismatch   = 0;
	int         tests_run    = 0;
	int         cyc          = 0;
	int         dens         = 9;
	int         ph           = 0;
	int         n;
	int         c1;

	// A short low-rate frame keeps the run brief; expectations scale with it.
	sdc_top #(.LOW_FRAME(13'd64)) i_sdc_top (
		.clk_i(clk_i), .resetn_i(resetn_i), .sel_i(sel_i),
		.enable_i(enable_i), .write_i(write_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .ana_enable_i(ana_enable_i),
		.mod_bit_i(mod_bit_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.mod_clk_o(mod_clk_o), .mod_rst_o(mod_rst_o),
		.mod_chan_o(mod_chan_o), .ana_en_o(ana_en_o)
	);

	// Bus clock of 100 ns and a free running cycle count for spacing checks.
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc++;

	task automatic test_done();
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// Read data is judged at the edge that closes the access cycle.
	always @(posedge clk_i)
	begin
		if (chk)
		begin
			e = notes.pop_front();
			cmp(rdata_o & e.m, e.v & e.m);
		end
	end

	// One setup and one access cycle; a read leaves its expectation behind.
	task automatic bus(input logic w, input sdc_addr_t a, input sdc_word_t v,
		input sdc_word_t m);
		@(negedge clk_i);
		sel_i = 1'b1;
		enable_i = 1'b0;
		write_i = w;
		addr_i = a;
		wdata_i = v;
		@(negedge clk_i);
		enable_i = 1'b1;
		if (!w)
		begin
			notes.push_back('{v, m});
			chk = 1'b1;
		end
		@(negedge clk_i);
		sel_i = 1'b0;
		enable_i = 1'b0;
		chk = 1'b0;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return mod_clk_o;
			1: return mod_rst_o;
			default: return irq_o;
		endcase
	endfunction

	// Cycles until the next rising edge of a watched output, bounded.
	task automatic rise(input int s, output int cnt);
		logic p;
		cnt = 0;
		p = pick(s);
		forever
		begin
			@(posedge clk_i);
			#1;
			cnt++;
			if (pick(s) === 1'b1 && p === 1'b0)
				break;
			p = pick(s);
			if (cnt > 30000)
			begin
				n_mismatch++;
				test_done();
			end
		end
	endtask

	// A change of the modulator channel marks the store of the last frame.
	task automatic wait_chan(input logic [1:0] c, output int cnt);
		cnt = 0;
		while (mod_chan_o !== c)
		begin
			@(posedge clk_i);
			#1;
			cnt++;
			if (cnt > 30000)
			begin
				n_mismatch++;
				test_done();
			end
		end
	endtask

	initial
	begin
		void'($urandom(88457));
		// Density of ones is dens in 17, a period prime to the tick spacing,
		// so the sample sits well inside the 21-bit range with a known sign.
		ph = $urandom % 17;
		fork
			forever
			begin
				@(negedge clk_i);
				ph = (ph + 1) % 17;
				mod_bit_i = (ph < dens);
			end
		join_none
		repeat (20) @(negedge clk_i);
		resetn_i = 1'b1;
		bus(0, 8'h20, 16'h0000, 16'hFFFF);
		bus(0, 8'h30, 16'h0000, 16'hFFFF);
		bus(0, 8'h28, 16'h0000, 16'hFFFF);
		repeat (4)
		begin
			d = 16'($urandom);
			bus(1, 8'h20, d, 16'h0000);
			bus(0, 8'h20, d & 16'h4F70, 16'hFFFF);
		end
		bus(1, 8'h20, 16'hFFFF, 16'h0000);
		bus(0, 8'h20, 16'h4F70, 16'hFFFF);
		bus(1, 8'h20, 16'h0F00, 16'h0000);
		bus(1, 8'h30, 16'h0003, 16'h0000);
		@(negedge clk_i);
		ana_enable_i = 1'b1;
		rise(0, n);
		rise(0, n);
		cmp(n, 6);
		cmp(ana_en_o, 1'b1);
		bus(1, 8'h30, 16'h0002, 16'h0000);
		rise(0, n);
		rise(0, n);
		cmp(n, 4);
		// Round robin: each channel takes one full frame, in order.
		wait_chan(2'd1, n);
		wait_chan(2'd2, n);
		cmp(n, 2048);
		wait_chan(2'd3, n);
		cmp(n, 2048);
		wait_chan(2'd0, n);
		repeat (3) @(posedge clk_i);
		#1;
		cmp(irq_o, 1'b1);
		// The run began on channel 3, so channel 3 was stored twice.
		bus(0, 8'h20, 16'h2F0F, 16'hFFFF);
		bus(1, 8'h20, 16'h0F0F, 16'h0000);
		bus(0, 8'h00, 16'h0000, 16'h8000);
		repeat (2) @(posedge clk_i);
		#1;
		cmp(irq_o, 1'b0);
		bus(0, 8'h20, 16'h0F0E, 16'hFFFF);
		// Storing channel 1 over its unread sample raises overrun.
		wait_chan(2'd1, n);
		wait_chan(2'd2, n);
		repeat (3) @(posedge clk_i);
		bus(0, 8'h20, 16'h2000, 16'h2000);
		bus(1, 8'h20, 16'h2F0F, 16'h0000);
		bus(0, 8'h20, 16'h2F0F, 16'hFFFF);
		bus(1, 8'h20, 16'h0F00, 16'h0000);
		bus(0, 8'h20, 16'h0F00, 16'hFFFF);
		// Single channel 2 with only its enable; one frame in four is kept.
		dens = 8;
		bus(1, 8'h20, 16'h0460, 16'h0000);
		rise(2, n);
		c1 = cyc;
		bus(0, 8'h20, 16'h0464, 16'hFFFF);
		bus(0, 8'h10, 16'h0000, 16'h0000);
		rise(2, n);
		cmp(cyc - c1, 8192);
		cmp(mod_chan_o, 2'd2);
		bus(0, 8'h10, 16'h8000, 16'h8000);
		repeat (2) @(posedge clk_i);
		#1;
		cmp(irq_o, 1'b0);
		// Low-rate frames span LOW_FRAME ticks of four bus clocks.
		bus(1, 8'h20, 16'h4000, 16'h0000);
		rise(1, n);
		rise(1, n);
		cmp(n, 256);
		// A prescale of 1 must hold the oversampling clock still.
		bus(1, 8'h30, 16'h0001, 16'h0000);
		repeat (10) @(posedge clk_i);
		#1;
		c1 = mod_clk_o;
		n = 0;
		repeat (50)
		begin
			@(posedge clk_i);
			#1;
			if (mod_clk_o !== 1'(c1))
				n++;
		end
		cmp(n, 0);
		@(negedge clk_i);
		ana_enable_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		cmp(ana_en_o, 1'b0);
		test_done();
	end
endmodule
